// file: ocdt_clock_ctrl.sv
// oscillator control, clock divider and fast rc trim registers on apb
//
// Operation
// - monitor on: switch_lock freezes source selection
// - monitor off: selection never locked
// - pin_map_lock needs unlock; one-way blocks clear
// - pll lock bit mirrors pll lock
// - lock bit zero while switching, on non-pll source or with pll_enable_bit off
// - clock_fail_flag set on detected failure
// - primary_sleep_keep keeps primary running asleep
// - secondary_osc_enable turns secondary oscillator on
// - switch_request starts switch, hardware clears it
// - interrupt clears ratio enable when recover set
// - ratio select gives 1:2 to the n
// - ratio enable off forces 1:1
// - fast rc postscale 2^n, code 7 256
// - system postscale divides by 1,2,4,8
// - pll_enable_bit turns the pll on
// - divider bits 4..0 read zero
// - signed trim, zero is calibrated centre
// - trim steps need not be even
// - any of seven sources selectable while idle and not locked
// - primary submode fixed by configuration only
// - switching disabled holds switch_request at zero
// - source codes per new_source_select encoding
`timescale 1ns/1ps
`default_nettype none

module ocdt_clock_ctrl (
	input wire logic ref_clk,
	input wire logic reset,
	input wire logic [11:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic monitor_config_msb,
	input wire logic switching_enabled,
	input wire logic pin_map_one_way,
	input wire logic pin_map_unlock,
	input wire logic [2:0] reset_source_config,
	input wire logic [1:0] primary_submode_config,
	input wire logic pll_lock_pin,
	input wire logic clock_fail_pin,
	input wire logic source_ready_pin,
	input wire logic interrupt_event,
	input wire logic sleep_mode,
	output logic primary_osc_run,
	output logic [1:0] primary_submode,
	output logic secondary_osc_run,
	output logic pll_run,
	output logic [2:0] current_source,
	output logic switch_busy,
	output logic pin_map_locked,
	output logic [2:0] peripheral_ratio_log2,
	output logic [3:0] fast_rc_div_log2,
	output logic [1:0] system_div_log2,
	output logic [5:0] fast_rc_trim_out
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (reset);

	// register state
	ocdt_pkg::ocdt_state_t state_ff, nxt_state;
	logic sw_req_ff, nxt_sw_req;
	logic sw_lock_ff, nxt_sw_lock;
	logic pin_lock_ff, nxt_pin_lock;
	logic pll_lock_ff, nxt_pll_lock;
	logic cf_ff, nxt_cf;
	logic pslp_ff, nxt_pslp;
	logic secen_ff, nxt_secen;
	logic [2:0] new_src_ff, nxt_new_src;
	logic [2:0] cur_src_ff, nxt_cur_src;
	logic [15:0] div_ff, nxt_div;
	logic [5:0] trim_ff, nxt_trim;
	logic [31:0] prdata_ff, nxt_prdata;
	logic [2:0] pin_meta_ff, pin_sync_ff;

	// bus decode
	wire logic setup = psel && !penable;
	wire logic wr_en = psel && penable && pwrite;
	wire logic hit_osc = paddr == ocdt_pkg::OFS_OSC;
	wire logic hit_div = paddr == ocdt_pkg::OFS_DIV;
	wire logic hit_trim = paddr == ocdt_pkg::OFS_TRIM;
	wire logic addr_hit = hit_osc || hit_div || hit_trim;
	wire logic wr_osc_lo = wr_en && hit_osc && pstrb[0];
	wire logic wr_osc_hi = wr_en && hit_osc && pstrb[1];
	wire logic wr_div_lo = wr_en && hit_div && pstrb[0];
	wire logic wr_div_hi = wr_en && hit_div && pstrb[1];
	wire logic wr_trim = wr_en && hit_trim && pstrb[0];

	// synchronised pins: pll lock, clock failure, new source stable
	wire logic pll_sync = pin_sync_ff[0];
	wire logic fail_sync = pin_sync_ff[1];
	wire logic ready_sync = pin_sync_ff[2];

	// lock only counts with the monitor configured on
	wire logic lock_active = monitor_config_msb && sw_lock_ff;
	wire logic idle = state_ff == ocdt_pkg::OCDT_IDLE;
	wire logic waiting = state_ff == ocdt_pkg::OCDT_WAIT;
	// reserved code is treated like a redundant request and dropped
	wire logic redundant = (new_src_ff == cur_src_ff)
		|| (new_src_ff == ocdt_pkg::SRC_RSVD);
	wire logic start_sw = idle && sw_req_ff && !redundant;
	wire logic drop_sw = idle && sw_req_ff && redundant;
	wire logic new_pll = ocdt_pkg::src_uses_pll(new_src_ff);
	wire logic done_sw = waiting && ready_sync
		&& (!new_pll || pll_sync);
	wire logic sw_set = wr_osc_lo && !lock_active
		&& pwdata[ocdt_pkg::OSC_SWREQ];
	// selection frozen under lock and while a switch is in flight
	wire logic new_wr = wr_osc_hi && !lock_active && idle;

	// divider fields
	wire logic recover_on_interrupt = div_ff[ocdt_pkg::DIV_ROI];
	wire logic peripheral_ratio_enable = div_ff[ocdt_pkg::DIV_DZEN];
	wire logic [2:0] peripheral_ratio_select_sel = div_ff[ocdt_pkg::DIV_DZ_LSB +: 3];
	wire logic [2:0] frc_code = div_ff[ocdt_pkg::DIV_FRC_LSB +: 3];
	wire logic pll_en = div_ff[ocdt_pkg::DIV_PLL_ENABLE_BIT];

	// pin inputs pass two flops before any logic reads them
	always_ff @(posedge ref_clk) begin
		pin_meta_ff <= {source_ready_pin, clock_fail_pin, pll_lock_pin};
		pin_sync_ff <= pin_meta_ff;
	end

	// switch engine: wait for the new source, then adopt it
	always_comb begin
		nxt_state = state_ff;
		nxt_cur_src = cur_src_ff;
		unique case (state_ff)
			ocdt_pkg::OCDT_IDLE: begin
				if (start_sw) begin
					nxt_state = ocdt_pkg::OCDT_WAIT;
				end
			end
			ocdt_pkg::OCDT_WAIT: begin
				if (done_sw) begin
					nxt_state = ocdt_pkg::OCDT_IDLE;
					nxt_cur_src = new_src_ff;
				end
			end
			default: begin
				nxt_state = ocdt_pkg::OCDT_IDLE;
			end
		endcase
	end

	// switch request: software sets, hardware clears when done
	always_comb begin
		nxt_sw_req = sw_req_ff;
		if (drop_sw || done_sw) begin
			nxt_sw_req = 1'b0;
		end
		if (sw_set) begin
			nxt_sw_req = 1'b1;
		end
		if (!switching_enabled) begin
			nxt_sw_req = 1'b0;
		end
	end

	// oscillator_control low byte and selection
	always_comb begin
		nxt_sw_lock = sw_lock_ff;
		nxt_pslp = pslp_ff;
		nxt_secen = secen_ff;
		nxt_pin_lock = pin_lock_ff;
		nxt_new_src = new_src_ff;
		nxt_cf = cf_ff;
		if (wr_osc_lo) begin
			nxt_sw_lock = pwdata[ocdt_pkg::OSC_SWLK];
			nxt_pslp = pwdata[ocdt_pkg::OSC_PSLP];
			nxt_secen = pwdata[ocdt_pkg::OSC_SECEN];
			// pin lock moves only after unlock; one-way forbids clear
			if (pin_map_unlock && !(pin_map_one_way && pin_lock_ff)) begin
				nxt_pin_lock = pwdata[ocdt_pkg::OSC_PINLK];
			end
			if (!pwdata[ocdt_pkg::OSC_CF]) begin
				nxt_cf = 1'b0;
			end
		end
		if (new_wr) begin
			nxt_new_src = pwdata[ocdt_pkg::OSC_NEW_LSB +: 3];
		end
		if (start_sw) begin
			nxt_cf = 1'b0;
		end
		// a failure in the clearing cycle is kept
		if (fail_sync) begin
			nxt_cf = 1'b1;
		end
	end

	// lock status: real lock, pll running, pll source, no switch under way
	assign nxt_pll_lock = pll_sync && pll_run
		&& ocdt_pkg::src_uses_pll(cur_src_ff) && idle;

	// clock_divider; interrupt recovery beats a same-cycle write
	always_comb begin
		nxt_div = div_ff;
		if (wr_div_hi) begin
			nxt_div[15:8] = pwdata[15:8];
		end
		if (wr_div_lo) begin
			nxt_div[7:5] = pwdata[7:5];
		end
		if (interrupt_event && nxt_div[ocdt_pkg::DIV_ROI]) begin
			nxt_div[ocdt_pkg::DIV_DZEN] = 1'b0;
		end
		nxt_div[4:0] = 5'h00;
	end

	// trim is stored as written; its effect on frequency is analog
	assign nxt_trim = wr_trim ? pwdata[5:0] : trim_ff;

	// read data is latched in the setup cycle, shown in access
	wire logic [15:0] osc_rd = {1'b0, cur_src_ff, 1'b0, new_src_ff,
		sw_lock_ff, pin_lock_ff, pll_lock_ff, 1'b0, cf_ff,
		pslp_ff, secen_ff, sw_req_ff};
	wire logic [15:0] sel_rd = hit_osc ? osc_rd
		: hit_div ? {div_ff[15:5], 5'h00}
		: hit_trim ? {10'h000, trim_ff}
		: 16'h0000;
	assign nxt_prdata = (setup && !pwrite) ? {16'h0000, sel_rd}
		: prdata_ff;

	// state registers; selections load from the reset straps
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			state_ff <= ocdt_pkg::OCDT_IDLE;
			sw_req_ff <= 1'b0;
			sw_lock_ff <= 1'b0;
			pin_lock_ff <= 1'b0;
			pll_lock_ff <= 1'b0;
			cf_ff <= 1'b0;
			pslp_ff <= 1'b0;
			secen_ff <= 1'b0;
			new_src_ff <= reset_source_config;
			cur_src_ff <= reset_source_config;
			div_ff <= ocdt_pkg::DIV_RESET;
			trim_ff <= ocdt_pkg::TRIM_RESET;
			prdata_ff <= 32'h0000_0000;
		end else begin
			state_ff <= nxt_state;
			sw_req_ff <= nxt_sw_req;
			sw_lock_ff <= nxt_sw_lock;
			pin_lock_ff <= nxt_pin_lock;
			pll_lock_ff <= nxt_pll_lock;
			cf_ff <= nxt_cf;
			pslp_ff <= nxt_pslp;
			secen_ff <= nxt_secen;
			new_src_ff <= nxt_new_src;
			cur_src_ff <= nxt_cur_src;
			div_ff <= nxt_div;
			trim_ff <= nxt_trim;
			prdata_ff <= nxt_prdata;
		end
	end

	// bus answers: zero wait states, error on unmapped address
	assign pready = 1'b1;
	assign pslverr = psel && penable && !addr_hit;
	assign prdata = prdata_ff;

	// oscillator enables; primary submode only from configuration
	wire logic pri_used = ocdt_pkg::src_uses_pri(cur_src_ff)
		|| (waiting && ocdt_pkg::src_uses_pri(new_src_ff));
	assign primary_osc_run = pri_used
		&& (!sleep_mode || pslp_ff);
	assign primary_submode = primary_submode_config;
	assign secondary_osc_run = secen_ff
		|| cur_src_ff == ocdt_pkg::SRC_SEC;
	assign pll_run = pll_en;
	assign current_source = cur_src_ff;
	assign switch_busy = waiting;
	assign pin_map_locked = pin_lock_ff;

	// divide ratios as powers of two
	assign peripheral_ratio_log2 = peripheral_ratio_enable ? peripheral_ratio_select_sel : 3'h0;
	assign fast_rc_div_log2 = (frc_code == ocdt_pkg::FRC_CODE_TOP)
		? ocdt_pkg::FRC_LOG2_TOP : {1'b0, frc_code};
	// slow codes are the caller's job to avoid while usb runs
	assign system_div_log2 = div_ff[ocdt_pkg::DIV_SYS_LSB +: 2];
	assign fast_rc_trim_out = trim_ff;

	// checks
	a_lock_holds_sel: assert property (
		lock_active && wr_osc_hi |=> $stable(new_src_ff))
		else $error("selection changed under switch lock");
	a_nolock_cfg_off: assert property (
		!monitor_config_msb && wr_osc_hi && idle
		|=> new_src_ff == $past(pwdata[10:8]))
		else $error("selection write lost with monitor off");
	a_pll_lock_switch: assert property (
		waiting |=> !pll_lock_ff)
		else $error("pll lock bit set during switch");
	a_pll_lock_cause: assert property (
		pll_lock_ff |-> $past(pll_sync) && $past(pll_run))
		else $error("pll lock bit without pll lock");
	a_fail_sticky: assert property (
		fail_sync |=> cf_ff)
		else $error("clock failure not flagged");
	a_swreq_cfg_off: assert property (
		!switching_enabled |=> !sw_req_ff)
		else $error("switch request set while disabled");
	a_switch_done: assert property (
		done_sw && !sw_set |=> !sw_req_ff
		&& cur_src_ff == $past(new_src_ff) ##1 idle)
		else $error("switch completion not reported");
	a_roi_clear: assert property (
		interrupt_event && recover_on_interrupt |=> !peripheral_ratio_enable ##0 peripheral_ratio_log2 == 3'h0)
		else $error("interrupt did not restore 1:1");
	a_div_low_zero: assert property (
		setup && !pwrite && hit_div |=> prdata[4:0] == 5'h00)
		else $error("divider low bits not zero");
	a_one_way: assert property (
		pin_lock_ff && pin_map_one_way |=> pin_lock_ff)
		else $error("one-way pin lock cleared");

	// divide ratio selection and recovery
	a_ratio_applied: assert property (
		peripheral_ratio_enable |-> peripheral_ratio_log2 == peripheral_ratio_select_sel)
		else $error("ratio select not applied");
	a_ratio_off: assert property (
		!peripheral_ratio_enable |-> peripheral_ratio_log2 == 3'h0)
		else $error("ratio not 1:1 with enable off");
	a_peripheral_ratio_enable_hold: assert property (
		!recover_on_interrupt && !wr_div_hi |=> $stable(peripheral_ratio_enable))
		else $error("ratio enable moved without recovery");

	// fast rc postscale codes; system postscale, pll enable and trim follow their writes
	a_frc_top_code: assert property (
		frc_code == ocdt_pkg::FRC_CODE_TOP
		|-> fast_rc_div_log2 == ocdt_pkg::FRC_LOG2_TOP)
		else $error("postscale code 7 not divide by 256");
	a_frc_low_codes: assert property (
		frc_code != ocdt_pkg::FRC_CODE_TOP
		|-> fast_rc_div_log2 == {1'b0, frc_code})
		else $error("postscale code not a power of two");
	a_sys_postscale: assert property (
		wr_div_lo |=> system_div_log2
		== $past(pwdata[ocdt_pkg::DIV_SYS_LSB +: 2]))
		else $error("system postscale not written");
	a_pll_follows: assert property (
		wr_div_lo |=> pll_run
		== $past(pwdata[ocdt_pkg::DIV_PLL_ENABLE_BIT]))
		else $error("pll enable not written");
	a_trim_store: assert property (
		wr_trim |=> fast_rc_trim_out == $past(pwdata[5:0]))
		else $error("trim not stored");

	// oscillator_control bits and the switch engine
	a_sec_write: assert property (
		wr_osc_lo
		|=> secen_ff == $past(pwdata[ocdt_pkg::OSC_SECEN]))
		else $error("secondary enable not written");
	a_sleep_keep: assert property (
		sleep_mode && !pslp_ff |-> !primary_osc_run)
		else $error("primary runs in sleep without keep");
	a_pin_needs_unlock: assert property (
		!pin_map_unlock |=> $stable(pin_lock_ff))
		else $error("pin lock moved without unlock");
	a_swreq_refused: assert property (
		lock_active && !sw_req_ff |=> !sw_req_ff)
		else $error("switch request set under lock");
	a_cur_stable: assert property (
		idle |=> $stable(cur_src_ff))
		else $error("current source moved outside a switch");
	a_lock_nonpll: assert property (
		!ocdt_pkg::src_uses_pll(cur_src_ff) |=> !pll_lock_ff)
		else $error("pll lock bit set on non-pll source");
	a_nosw_idle: assert property (
		!switching_enabled && !sw_req_ff && idle |=> idle)
		else $error("switch started while disabled");
endmodule // ocdt_clock_ctrl

`default_nettype wire

// file: ocdt_pkg.sv
// shared constants for the oscillator control, divider and tune block
package ocdt_pkg;
	// register byte offsets on the apb bus
	localparam logic [11:0] OFS_OSC = 12'h000;
	localparam logic [11:0] OFS_DIV = 12'h004;
	localparam logic [11:0] OFS_TRIM = 12'h008;

	// oscillator_control field positions
	localparam int OSC_SWREQ = 0;
	localparam int OSC_SECEN = 1;
	localparam int OSC_PSLP = 2;
	localparam int OSC_CF = 3;
	localparam int OSC_PLLLK = 5;
	localparam int OSC_PINLK = 6;
	localparam int OSC_SWLK = 7;
	localparam int OSC_NEW_LSB = 8;
	localparam int OSC_CUR_LSB = 12;

	// clock_divider field positions
	localparam int DIV_PLL_ENABLE_BIT = 5;
	localparam int DIV_SYS_LSB = 6;
	localparam int DIV_FRC_LSB = 8;
	localparam int DIV_DZEN = 11;
	localparam int DIV_DZ_LSB = 12;
	localparam int DIV_ROI = 15;

	// reset values
	localparam logic [15:0] DIV_RESET = 16'h0100;
	localparam logic [5:0] TRIM_RESET = 6'h00;

	// source codes of new_source_select
	localparam logic [2:0] SRC_FRC = 3'h0;
	localparam logic [2:0] SRC_FRC_PLL = 3'h1;
	localparam logic [2:0] SRC_PRI = 3'h2;
	localparam logic [2:0] SRC_PRI_PLL = 3'h3;
	localparam logic [2:0] SRC_SEC = 3'h4;
	localparam logic [2:0] SRC_LOW_POWER_RC_SOURCE = 3'h5;
	localparam logic [2:0] SRC_RSVD = 3'h6;
	localparam logic [2:0] SRC_FRC_DIV = 3'h7;

	// postscale code whose divide is 256 rather than 128
	localparam logic [2:0] FRC_CODE_TOP = 3'h7;
	localparam logic [3:0] FRC_LOG2_TOP = 4'h8;

	// switch engine states
	typedef enum logic [1:0] {
		OCDT_IDLE = 2'b01,
		OCDT_WAIT = 2'b10
	} ocdt_state_t;

	// true for the two sources that run through the pll
	function automatic logic src_uses_pll(input logic [2:0] code);
		return (code == SRC_FRC_PLL) || (code == SRC_PRI_PLL);
	endfunction

	// true for the two primary-oscillator sources
	function automatic logic src_uses_pri(input logic [2:0] code);
		return (code == SRC_PRI) || (code == SRC_PRI_PLL);
	endfunction
endpackage

// file: tb_oscillator_control_divider_tune.sv
// self-checking bench for the oscillator control, divider and trim block
`timescale 1ns/1ps
`default_nettype none
module tb_oscillator_control_divider_tune;
	// stimulus driven by the bench, design outputs observed
	logic ref_clk = 1'h0;
	logic reset = 1'h1;
	logic [11:0] paddr = 12'h000;
	logic psel = 1'h0;
	logic penable = 1'h0;
	logic pwrite = 1'h0;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [3:0] pstrb = 4'hf;
	logic mon = 1'h0;
	logic sw_en = 1'h1;
	logic one_way = 1'h0;
	logic unlock = 1'h0;
	logic irq = 1'h0;
	logic pll_pin = 1'h0;
	logic fail_pin = 1'h0;
	logic sleep = 1'h0;
	logic [31:0] prdata;
	logic pready, pslverr, pri_run, sec_run, pll_run, busy, pin_lk;
	logic [1:0] subm, sys_div;
	logic [2:0] cur_src, ratio;
	logic [3:0] frc_div;
	logic [5:0] trim;
	int err_total = 0;
	int n_compared = 0;
	int cyc = 0;

	ocdt_clock_ctrl i_ocdt_clock_ctrl (.ref_clk(ref_clk), .reset(reset),
		.paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
		.pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .monitor_config_msb(mon),
		.switching_enabled(sw_en), .pin_map_one_way(one_way),
		.pin_map_unlock(unlock), .reset_source_config(3'h0),
		.primary_submode_config(2'h1), .pll_lock_pin(pll_pin),
		.clock_fail_pin(fail_pin), .source_ready_pin(1'h1),
		.interrupt_event(irq), .sleep_mode(sleep),
		.primary_osc_run(pri_run),
		.primary_submode(subm), .secondary_osc_run(sec_run),
		.pll_run(pll_run), .current_source(cur_src), .switch_busy(busy),
		.pin_map_locked(pin_lk), .peripheral_ratio_log2(ratio),
		.fast_rc_div_log2(frc_div), .system_div_log2(sys_div),
		.fast_rc_trim_out(trim));

	// clock, and a cycle ceiling so a stuck handshake cannot hang the run
	always #5 ref_clk = ~ref_clk;
	always @(posedge ref_clk) begin
		cyc++;
		if (cyc == 5000) begin
			err_total++;
			tally_and_finish();
		end
	end

	task automatic tally_and_finish();
		$display("compared %0d mismatches %0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, exp, input string what);
		n_compared++;
		if (got !== exp) begin
			err_total++;
			$display("CHECK FAILED %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask

	// one apb transfer: setup, then access held until pready is seen high
	task automatic apb(input logic we, input logic [11:0] a,
		input logic [31:0] d, input logic [3:0] s,
		output logic [31:0] rd, output logic er);
		@(posedge ref_clk);
		psel <= 1'h1;
		penable <= 1'h0;
		pwrite <= we;
		paddr <= a;
		pwdata <= d;
		pstrb <= s;
		@(posedge ref_clk);
		penable <= 1'h1;
		do @(posedge ref_clk); while (pready !== 1'h1);
		rd = prdata;
		er = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
		// return mid-cycle so callers see the written registers settled
		@(negedge ref_clk);
	endtask

	task automatic wr(input logic [11:0] a, input logic [31:0] d,
		input logic [3:0] s);
		logic [31:0] r;
		logic e;
		apb(1'h1, a, d, s, r, e);
	endtask

	task automatic rdc(input logic [11:0] a, input logic [31:0] x,
		input string w);
		logic [31:0] r;
		logic e;
		apb(1'h0, a, 32'h0000_0000, 4'hf, r, e);
		chk(r, x, w);
	endtask

	// polls the request bit; the switch ends when hardware drops it
	task automatic wait_sw();
		logic [31:0] r;
		logic e;
		for (int n = 0; n < 30; n++) begin
			apb(1'h0, ocdt_pkg::OFS_OSC, 32'h0000_0000, 4'hf, r, e);
			if (r[0] === 1'h0)
				break;
		end
		chk(32'(r[0]), 32'h0, "switch done");
	endtask

	task automatic irq_pulse();
		@(posedge ref_clk);
		irq <= 1'h1;
		@(posedge ref_clk);
		irq <= 1'h0;
	endtask

	task automatic t_reset();
		rdc(ocdt_pkg::OFS_OSC, 32'h0000_0000, "osc reset");
		rdc(ocdt_pkg::OFS_DIV, 32'h0000_0100, "div reset");
		rdc(ocdt_pkg::OFS_TRIM, 32'h0000_0000, "trim reset");
		chk(32'(frc_div), 32'h1, "frc div reset");
	endtask

	// every field at its top code, then interrupt recovery on and off
	task automatic t_div();
		// no usb in this bench, so codes 10 and 11 are legal
		wr(ocdt_pkg::OFS_DIV, 32'h0000_ffff, 4'h3);
		rdc(ocdt_pkg::OFS_DIV, 32'h0000_ffe0, "div low bits");
		chk(32'(ratio), 32'h7, "ratio 1:128");
		chk(32'(frc_div), 32'h8, "frc code 7");
		chk(32'(sys_div), 32'h3, "sys div 8");
		chk(32'(pll_run), 32'h1, "pll on");
		irq_pulse();
		rdc(ocdt_pkg::OFS_DIV, 32'h0000_f7e0, "roi clears");
		chk(32'(ratio), 32'h0, "ratio 1:1");
		wr(ocdt_pkg::OFS_DIV, 32'h0000_3a40, 4'h3);
		irq_pulse();
		rdc(ocdt_pkg::OFS_DIV, 32'h0000_3a40, "roi off keeps");
		chk(32'(ratio), 32'h3, "ratio 1:8");
		chk(32'(frc_div), 32'h2, "frc div 4");
		chk(32'(sys_div), 32'h1, "sys div 2");
		chk(32'(pll_run), 32'h0, "pll off");
	endtask

	task automatic t_trim();
		wr(ocdt_pkg::OFS_TRIM, 32'h0000_ffdf, 4'h3);
		rdc(ocdt_pkg::OFS_TRIM, 32'h0000_001f, "trim max");
		wr(ocdt_pkg::OFS_TRIM, 32'h0000_0020, 4'h3);
		chk(32'(trim), 32'h20, "trim min");
	endtask

	task automatic t_bad();
		logic [31:0] r;
		logic e;
		apb(1'h0, 12'h00c, 32'h0000_0000, 4'hf, r, e);
		chk({r[31:1], e}, 32'h1, "unmapped read");
	endtask

	// switch, then locked writes, then the switch write again with monitor off and secondary enabled
	task automatic t_switch();
		wr(ocdt_pkg::OFS_OSC, 32'h0000_0401, 4'h3);
		wait_sw();
		chk(32'(cur_src), 32'h4, "to secondary");
		rdc(ocdt_pkg::OFS_OSC, 32'h0000_4400, "osc after");
		@(posedge ref_clk);
		mon <= 1'h1;
		wr(ocdt_pkg::OFS_OSC, 32'h0000_0080, 4'h1);
		wr(ocdt_pkg::OFS_OSC, 32'h0000_0581, 4'h3);
		rdc(ocdt_pkg::OFS_OSC, 32'h0000_4480, "locked");
		@(posedge ref_clk);
		mon <= 1'h0;
		wr(ocdt_pkg::OFS_OSC, 32'h0000_0583, 4'h3);
		wait_sw();
		chk(32'(cur_src), 32'h5, "to low_power_rc_source");
		chk(32'(sec_run), 32'h1, "sec on");
		wr(ocdt_pkg::OFS_OSC, 32'h0000_0500, 4'h3);
		chk(32'(sec_run), 32'h0, "sec off");
	endtask

	// a one-cycle failure pulse must leave the flag set until written 0
	task automatic t_fail();
		@(posedge ref_clk);
		fail_pin <= 1'h1;
		@(posedge ref_clk);
		fail_pin <= 1'h0;
		repeat (3) @(posedge ref_clk);
		rdc(ocdt_pkg::OFS_OSC, 32'h0000_5508, "fail flagged");
		wr(ocdt_pkg::OFS_OSC, 32'h0000_0000, 4'h1);
		rdc(ocdt_pkg::OFS_OSC, 32'h0000_5500, "fail cleared");
	endtask

	// primary with pll: lock bit follows pll enable, then sleep keep
	task automatic t_prim();
		@(posedge ref_clk);
		sw_en <= 1'h1;
		pll_pin <= 1'h1;
		wr(ocdt_pkg::OFS_OSC, 32'h0000_0305, 4'h3);
		wait_sw();
		chk(32'(cur_src), 32'h3, "to primary pll");
		rdc(ocdt_pkg::OFS_OSC, 32'h0000_3344, "pll off no lock");
		wr(ocdt_pkg::OFS_DIV, 32'h0000_3a60, 4'h3);
		rdc(ocdt_pkg::OFS_OSC, 32'h0000_3364, "pll locked");
		@(posedge ref_clk);
		sleep <= 1'h1;
		@(negedge ref_clk);
		chk(32'(pri_run), 32'h1, "kept in sleep");
		wr(ocdt_pkg::OFS_OSC, 32'h0000_0300, 4'h1);
		chk(32'(pri_run), 32'h0, "off in sleep");
		@(posedge ref_clk);
		sleep <= 1'h0;
		@(negedge ref_clk);
		chk(32'(pri_run), 32'h1, "awake runs");
		wr(ocdt_pkg::OFS_DIV, 32'h0000_3a40, 4'h3);
		rdc(ocdt_pkg::OFS_OSC, 32'h0000_3340, "pll off unlocks");
	endtask

	task automatic t_pin();
		wr(ocdt_pkg::OFS_OSC, 32'h0000_0040, 4'h1);
		chk(32'(pin_lk), 32'h0, "no unlock");
		@(posedge ref_clk);
		unlock <= 1'h1;
		one_way <= 1'h1;
		wr(ocdt_pkg::OFS_OSC, 32'h0000_0040, 4'h1);
		chk(32'(pin_lk), 32'h1, "unlocked set");
		wr(ocdt_pkg::OFS_OSC, 32'h0000_0000, 4'h1);
		chk(32'(pin_lk), 32'h1, "one way");
	endtask

	task automatic t_nosw();
		@(posedge ref_clk);
		sw_en <= 1'h0;
		wr(ocdt_pkg::OFS_OSC, 32'h0000_0001, 4'h3);
		repeat (6) @(posedge ref_clk);
		chk({cur_src, busy}, 32'ha, "no switch");
		rdc(ocdt_pkg::OFS_OSC, 32'h0000_5040, "req held 0");
	endtask

	// reset for eight cycles, then each scenario in turn
	initial begin
		repeat (8) @(posedge ref_clk);
		reset <= 1'h0;
		t_reset();
		t_div();
		t_trim();
		t_bad();
		t_switch();
		t_fail();
		t_pin();
		t_nosw();
		t_prim();
		chk(32'(subm), 32'h1, "submode");
		tally_and_finish();
	end
endmodule // tb_oscillator_control_divider_tune
`default_nettype wire
